// File: design/host_bus_regs.svh
// named constants of the host bus agent
`ifndef HOST_BUS_REGS_SVH
`define HOST_BUS_REGS_SVH
`define ADDR_W         33
`define CMD_W          5
`define DATA_W         64
`define GROUP_W        16
`define GROUPS         4
`define BEATS          4
`define LINE_W         256
`define MAX_LOW_BITS   8
`define MCLK_NS        10
`define BUS_CLK_NS     160
`define TICKS_PER_BUS  8
`define TICK_CYC       (`BUS_CLK_NS / (`MCLK_NS * `TICKS_PER_BUS))
`define ADR_HALF_TICKS 4
`define RESP_TICKS     8
`endif

// File: design/host_bus_pkg.sv
// types shared by the host bus agent and its bench
`include "host_bus_regs.svh"
package host_bus_pkg;
   typedef struct packed {
      logic                  request_phase_strobe_n;
      logic [`CMD_W-1:0]     request_command_lines_n;
      logic [`ADDR_W-1:0]    host_address_lines_n;
      logic [1:0]            address_timing_strobes_n;
      logic [`DATA_W-1:0]    host_data_lines_n;
      logic [`GROUPS-1:0]    group_inversion_flags_n;
      logic [`GROUPS-1:0]    data_strobe_p_side_n;
      logic [`GROUPS-1:0]    data_strobe_n_side_n;
      logic                  snoop_clean_hit_n;
      logic                  snoop_modified_hit_n;
   } bus_pins_t;

   typedef struct packed {
      logic ads;
      logic cmd;
      logic addr;
      logic astb;
      logic data;
      logic dinv;
      logic dstb;
      logic hit;
   } bus_oe_t;

   typedef struct packed {
      logic               write;
      logic [`ADDR_W-1:0] addr;
      logic [`CMD_W-1:0]  cmd_a;
      logic [`CMD_W-1:0]  cmd_b;
   } req_t;

   typedef struct packed {
      logic clean;
      logic modified;
   } snp_resp_t;

   typedef enum logic [3:0] {
      IDLE     = 4'h0,
      ADR_A    = 4'h1,
      ADR_B    = 4'h2,
      WDAT     = 4'h3,
      RDAT     = 4'h4,
      SNP_ADR  = 4'h5,
      SNP_WAIT = 4'h6,
      SNP_RESP = 4'h7,
      WEND     = 4'h8
   } seq_state_t;
endpackage : host_bus_pkg

// File: design/host_bus_agent.sv
// processor-side agent driving the host bus pins
// Function
// RULE1: at most eight electrically low bits per group
// RULE2: four inversion flags travel with their groups
// RULE3: receiver restores true data using inversion flags
// RULE4: device leaves address lines undriven in processor cycles
// RULE5: device drives address lines for its snoops
// RULE6: two address transfers per bus clock
// RULE7: address driver also drives both address strobes
// RULE8: four data transfers per bus clock
// RULE9: strobe pair n times data group n
// RULE10: capture on falling edge of both strobes
// RULE11: pair members are separate edge strobes
// RULE12: clean copy asserts clean-hit result
// RULE13: modified copy asserts modified-hit result
// RULE14: modified-hit alone obliges supplying the line
// RULE15: both hit signals together mean snoop stall
// RULE16: command lines carry both request halves
// RULE17: phase strobe marks first request cycle
// RULE18: inversion decided per transfer and group
`include "host_bus_regs.svh"
module host_bus_agent #(
   parameter int TICK_CYC = `TICK_CYC
) (
   input  wire logic                   mclk_i,
   input  wire logic                   rstn_i,
   input  wire host_bus_pkg::bus_pins_t pins_i,
   output host_bus_pkg::bus_pins_t     pins_o,
   output host_bus_pkg::bus_oe_t       pins_oe_o,
   input  wire logic                   req_valid_i,
   output logic                        req_ready_o,
   input  wire host_bus_pkg::req_t     req_i,
   input  wire logic [`LINE_W-1:0]     wdata_i,
   output logic                        rd_valid_o,
   output logic [`LINE_W-1:0]          rd_data_o,
   output logic                        snp_valid_o,
   output host_bus_pkg::req_t          snp_req_o,
   input  wire logic                   snp_resp_valid_i,
   input  wire host_bus_pkg::snp_resp_t snp_resp_i,
   input  wire logic [`LINE_W-1:0]     snp_wdata_i
);
   import host_bus_pkg::*;

   localparam int TW = $clog2(TICK_CYC + 1);

   if (TICK_CYC < 1) begin : g_bad_tick
      $error("TICK_CYC must be at least one");
   end

   // count of electrically low bits in one group
   function automatic logic [4:0] count_low(input logic [`GROUP_W-1:0] e);
      logic [4:0] n;
      n = 5'h0;
      for (int i = 0; i < `GROUP_W; i++) begin
         n = n + {4'h0, ~e[i]};
      end
      return n;
   endfunction : count_low

   // active-low bus: plain image is the complement of the true word
   function automatic logic [`GROUP_W:0] dbi_encode(
      input logic [`GROUP_W-1:0] w);
      if (count_low(~w) > 5'(`MAX_LOW_BITS)) begin
         return {1'b0, w};
      end
      return {1'b1, ~w};
   endfunction : dbi_encode

   function automatic logic [`GROUP_W-1:0] dbi_decode(
      input logic [`GROUP_W-1:0] e, input logic inv_n);
      return inv_n ? ~e : e;
   endfunction : dbi_decode

   seq_state_t           state_reg;
   logic [TW-1:0]        tick_cnt_reg;
   logic                 tick;
   logic [2:0]           sub_reg;
   logic [1:0]           beat_reg;
   logic                 half_reg;
   logic [`LINE_W-1:0]   tx_line_reg;
   logic [`LINE_W-1:0]   rx_line_reg;
   req_t                 cur_req_reg;
   snp_resp_t            resp_reg;
   bus_pins_t            s1_reg;
   bus_pins_t            s2_reg;
   bus_pins_t            s3_reg;
   bus_pins_t            fell;
   logic [3:0][2:0]      rx_cnt_reg;
   logic                 rx_done;

   // one tick per eighth of a bus clock paces every strobe
   assign tick = (tick_cnt_reg == TW'(TICK_CYC - 1));

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tick_cnt_reg <= '0;
      end else if (tick) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + TW'(1);
      end
   end

   // data and strobes share one synchroniser depth, so they stay aligned
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s1_reg <= '1;
         s2_reg <= '1;
         s3_reg <= '1;
      end else begin
         s1_reg <= pins_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   assign fell = s3_reg & ~s2_reg;

   assign req_ready_o = (state_reg == IDLE) && tick
                        && !fell.request_phase_strobe_n;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg   <= IDLE;
         sub_reg     <= 3'h0;
         beat_reg    <= 2'h0;
         half_reg    <= 1'b0;
         tx_line_reg <= '0;
         cur_req_reg <= '0;
         resp_reg    <= '0;
         pins_o      <= '1;
         pins_oe_o   <= '0;
         snp_valid_o <= 1'b0;
         snp_req_o   <= '0;
      end else begin
         snp_valid_o <= 1'b0;
         case (state_reg)
            IDLE: begin
               pins_o    <= '1;
               pins_oe_o <= '0;
               if (fell.request_phase_strobe_n) begin
                  state_reg <= SNP_ADR;
               end else if (req_valid_i && req_ready_o) begin
                  cur_req_reg <= req_i;
                  tx_line_reg <= wdata_i;
                  sub_reg     <= 3'h0;
                  state_reg   <= ADR_A;
               end
            end
            ADR_A: if (tick) begin
               pins_oe_o.ads  <= 1'b1;
               pins_oe_o.cmd  <= 1'b1;
               pins_oe_o.addr <= 1'b1;
               pins_oe_o.astb <= 1'b1;
               sub_reg <= sub_reg + 3'h1;
               if (sub_reg == 3'h0) begin
                  pins_o.request_phase_strobe_n <= 1'b0; // [RULE17]
                  pins_o.request_command_lines_n <= ~cur_req_reg.cmd_a; // [RULE16]
                  pins_o.host_address_lines_n <= ~cur_req_reg.addr;
                  pins_o.address_timing_strobes_n <= 2'h3;
               end
               if (sub_reg == 3'(`ADR_HALF_TICKS / 2)) begin
                  pins_o.address_timing_strobes_n[0] <= 1'b0; // [RULE7]
               end
               if (sub_reg == 3'(`ADR_HALF_TICKS - 1)) begin
                  sub_reg   <= 3'h0;
                  state_reg <= ADR_B;
               end
            end
            ADR_B: if (tick) begin
               sub_reg <= sub_reg + 3'h1;
               if (sub_reg == 3'h0) begin
                  pins_o.request_phase_strobe_n <= 1'b1;
                  pins_o.request_command_lines_n <= ~cur_req_reg.cmd_b; // [RULE16]
                  pins_o.address_timing_strobes_n[0] <= 1'b1;
               end
               if (sub_reg == 3'(`ADR_HALF_TICKS / 2)) begin
                  // second transfer of the same bus clock [RULE6]
                  pins_o.address_timing_strobes_n[1] <= 1'b0; // [RULE7]
               end
               if (sub_reg == 3'(`ADR_HALF_TICKS - 1)) begin
                  pins_oe_o <= '0;
                  pins_o    <= '1;
                  beat_reg  <= 2'h0;
                  half_reg  <= 1'b0;
                  state_reg <= cur_req_reg.write ? WDAT : RDAT;
               end
            end
            WDAT: if (tick) begin
               pins_oe_o.data <= 1'b1;
               pins_oe_o.dinv <= 1'b1;
               pins_oe_o.dstb <= 1'b1;
               if (!half_reg) begin
                  for (int g = 0; g < `GROUPS; g++) begin
                     {pins_o.group_inversion_flags_n[g],
                      pins_o.host_data_lines_n[g*`GROUP_W +: `GROUP_W]}
                        <= dbi_encode(tx_line_reg[int'(beat_reg)*`DATA_W
                           + g*`GROUP_W +: `GROUP_W]); // [RULE1] [RULE2] [RULE18]
                  end
                  pins_o.data_strobe_p_side_n <= 4'hf;
                  pins_o.data_strobe_n_side_n <= 4'hf;
                  half_reg <= 1'b1;
               end else begin
                  // p falls on even beats, n on odd: four per bus clock
                  if (!beat_reg[0]) begin
                     pins_o.data_strobe_p_side_n <= 4'h0; // [RULE8] [RULE9]
                  end else begin
                     pins_o.data_strobe_n_side_n <= 4'h0; // [RULE9]
                  end
                  half_reg <= 1'b0;
                  beat_reg <= beat_reg + 2'h1;
                  if (beat_reg == 2'(`BEATS - 1)) begin
                     state_reg <= WEND;
                  end
               end
            end
            WEND: if (tick) begin
               pins_oe_o <= '0;
               pins_o    <= '1;
               state_reg <= IDLE;
            end
            RDAT: if (rx_done) begin
               state_reg <= IDLE;
            end
            SNP_ADR: begin
               // address pins stay undriven while the far end snoops
               if (fell.address_timing_strobes_n[0]) begin
                  snp_req_o.addr  <= ~s2_reg.host_address_lines_n;
                  snp_req_o.cmd_a <= ~s2_reg.request_command_lines_n;
                  snp_req_o.write <= 1'b0;
               end
               if (fell.address_timing_strobes_n[1]) begin
                  snp_req_o.cmd_b <= ~s2_reg.request_command_lines_n;
                  snp_valid_o <= 1'b1;
                  state_reg   <= SNP_WAIT;
               end
            end
            SNP_WAIT: begin
               // hold off the requester until the cache lookup answers
               pins_oe_o.hit <= 1'b1;
               pins_o.snoop_clean_hit_n    <= 1'b0; // [RULE15]
               pins_o.snoop_modified_hit_n <= 1'b0; // [RULE15]
               if (snp_resp_valid_i
                   && !(snp_resp_i.clean && snp_resp_i.modified)) begin
                  resp_reg    <= snp_resp_i;
                  tx_line_reg <= snp_wdata_i;
                  sub_reg     <= 3'h0;
                  state_reg   <= SNP_RESP;
               end
            end
            SNP_RESP: begin
               pins_o.snoop_clean_hit_n    <= ~resp_reg.clean; // [RULE12]
               pins_o.snoop_modified_hit_n <= ~resp_reg.modified; // [RULE13]
               if (tick) begin
                  sub_reg <= sub_reg + 3'h1;
                  if (sub_reg == 3'(`RESP_TICKS - 1)) begin
                     pins_oe_o.hit <= 1'b0;
                     pins_o.snoop_clean_hit_n    <= 1'b1;
                     pins_o.snoop_modified_hit_n <= 1'b1;
                     beat_reg <= 2'h0;
                     half_reg <= 1'b0;
                     if (resp_reg.modified && !resp_reg.clean) begin
                        state_reg <= WDAT; // [RULE14]
                     end else begin
                        state_reg <= IDLE;
                     end
                  end
               end
            end
            default: state_reg <= IDLE;
         endcase
      end
   end

   // each strobe edge-detected on its own, never as a differential level
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_cnt_reg  <= '0;
         rx_line_reg <= '0;
         rd_valid_o  <= 1'b0;
         rd_data_o   <= '0;
      end else begin
         rd_valid_o <= 1'b0;
         if (state_reg != RDAT) begin
            rx_cnt_reg <= '0;
         end else if (rx_done) begin
            rd_data_o  <= rx_line_reg;
            rd_valid_o <= 1'b1;
         end else begin
            for (int g = 0; g < `GROUPS; g++) begin
               if ((fell.data_strobe_p_side_n[g]
                    || fell.data_strobe_n_side_n[g]) // [RULE10] [RULE11]
                   && rx_cnt_reg[g] < 3'(`BEATS)) begin
                  rx_line_reg[int'(rx_cnt_reg[g])*`DATA_W
                     + g*`GROUP_W +: `GROUP_W] <= dbi_decode(
                     s2_reg.host_data_lines_n[g*`GROUP_W +: `GROUP_W],
                     s2_reg.group_inversion_flags_n[g]); // [RULE3]
                  rx_cnt_reg[g] <= rx_cnt_reg[g] + 3'h1;
               end
            end
         end
      end
   end

   always_comb begin
      rx_done = 1'b1;
      for (int g = 0; g < `GROUPS; g++) begin
         rx_done = rx_done && (rx_cnt_reg[g] == 3'(`BEATS));
      end
   end

   // helpers read only by the checks below
   logic dbi_ok;
   logic dbi_trip_ok;
   always_comb begin
      dbi_ok      = 1'b1;
      dbi_trip_ok = 1'b1;
      for (int g = 0; g < `GROUPS; g++) begin
         dbi_ok = dbi_ok && (count_low(pins_o.host_data_lines_n[g*`GROUP_W
                  +: `GROUP_W]) <= 5'(`MAX_LOW_BITS));
         dbi_trip_ok = dbi_trip_ok && (dbi_decode(
            pins_o.host_data_lines_n[g*`GROUP_W +: `GROUP_W],
            pins_o.group_inversion_flags_n[g]) == tx_line_reg[
            int'(beat_reg)*`DATA_W + g*`GROUP_W +: `GROUP_W]);
      end
   end

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rstn_i);

   a_dbi_low_limit: assert property ( // [RULE1]
      pins_oe_o.data |-> dbi_ok)
      else $error("too many low bits in a data group");
   a_dbi_round_trip: assert property ( // [RULE2] [RULE18]
      (state_reg == WDAT && half_reg) |-> dbi_trip_ok)
      else $error("driven group does not decode to its beat");
   a_addr_two_xfer: assert property ( // [RULE6]
      $fell(pins_o.address_timing_strobes_n[0]) |->
         ##[1:40] $fell(pins_o.address_timing_strobes_n[1]))
      else $error("second address transfer missing");
   a_addr_strobe_hold: assert property ( // [RULE7]
      $fell(pins_o.address_timing_strobes_n[0]) |->
         pins_oe_o.addr && $stable(pins_o.host_address_lines_n))
      else $error("address moved at its strobe");
   a_req_first_half: assert property ( // [RULE16] [RULE17]
      $fell(pins_o.request_phase_strobe_n) |-> pins_oe_o.cmd
         && pins_o.request_command_lines_n == ~cur_req_reg.cmd_a)
      else $error("first request half carries wrong command");
   a_req_second_half: assert property ( // [RULE16]
      $fell(pins_o.address_timing_strobes_n[1]) |->
         pins_o.request_command_lines_n == ~cur_req_reg.cmd_b)
      else $error("second request half carries wrong command");
   a_snoop_no_drive: assert property ( // [RULE4] [RULE5]
      state_reg == SNP_ADR |-> !pins_oe_o.addr && !pins_oe_o.ads)
      else $error("address driven during a far-end snoop");
   a_stall_both_hits: assert property ( // [RULE15]
      (state_reg == SNP_WAIT && $past(state_reg) == SNP_WAIT) |->
         pins_oe_o.hit && !pins_o.snoop_clean_hit_n
         && !pins_o.snoop_modified_hit_n)
      else $error("stall does not show both hit signals");
   a_hit_report: assert property ( // [RULE12] [RULE13]
      (state_reg == SNP_RESP && $past(state_reg) == SNP_RESP) |->
         pins_o.snoop_clean_hit_n == !resp_reg.clean
         && pins_o.snoop_modified_hit_n == !resp_reg.modified)
      else $error("snoop result differs from lookup");
   a_hitm_supplies: assert property ( // [RULE14]
      ($past(state_reg) == SNP_RESP && state_reg == WDAT) |->
         ##[1:8] pins_oe_o.data)
      else $error("modified line not supplied");
   a_strobe_separate: assert property ( // [RULE11]
      pins_oe_o.dstb |-> (~pins_o.data_strobe_p_side_n
         & ~pins_o.data_strobe_n_side_n) == 4'h0)
      else $error("both strobes of a pair low together");
   a_quad_beats: assert property ( // [RULE8] [RULE9]
      $rose(pins_oe_o.data) |-> ##[1:40]
         $fell(pins_o.data_strobe_p_side_n[0]) ##[1:12]
         $fell(pins_o.data_strobe_n_side_n[0]))
      else $error("data strobes do not alternate");
endmodule : host_bus_agent

// File: sim/host_bus_device.sv
// behavioural hub model on the far side of the host bus
`include "host_bus_regs.svh"
module host_bus_device (
   input  wire host_bus_pkg::bus_pins_t pins_i,
   output host_bus_pkg::bus_pins_t      pins_o,
   output host_bus_pkg::bus_oe_t        pins_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import host_bus_pkg::*;
   logic [`LINE_W-1:0] cap_line;
   logic [`ADDR_W-1:0] cap_addr;
   logic [`ADDR_W-1:0] cap_addr_b;
   logic [`CMD_W-1:0]  cap_cmd_a;
   logic [`CMD_W-1:0]  cap_cmd_b;
   logic               ads_a;
   logic               ads_b;
   logic               dbi_bad;
   int                 adr_seen;
   int                 beats [`GROUPS];

   initial begin
      pins_o = '1;
      pins_oe_o = '0;
   end

   task automatic clear;
      cap_line = '0;
      dbi_bad = 1'b0;
      adr_seen = 0;
      for (int g = 0; g < `GROUPS; g++) beats[g] = 0;
   endtask : clear

   // address lines are only sampled, never driven, in agent cycles
   always @(negedge pins_i.address_timing_strobes_n[0]) begin
      if (!pins_oe_o.astb) begin
         cap_addr  = ~pins_i.host_address_lines_n;
         cap_cmd_a = ~pins_i.request_command_lines_n;
         ads_a     = pins_i.request_phase_strobe_n;
      end
   end
   always @(negedge pins_i.address_timing_strobes_n[1]) begin
      if (!pins_oe_o.astb) begin
         cap_addr_b = ~pins_i.host_address_lines_n;
         cap_cmd_b  = ~pins_i.request_command_lines_n;
         ads_b      = pins_i.request_phase_strobe_n;
         adr_seen++;
      end
   end

   task automatic take(input int g);
      logic [15:0] w;
      logic        f;
      w = pins_i.host_data_lines_n[g*16 +: 16];
      f = pins_i.group_inversion_flags_n[g];
      if (16 - $countones(w) > `MAX_LOW_BITS) dbi_bad = 1'b1;
      cap_line[beats[g]*64 + g*16 +: 16] = f ? ~w : w;
      beats[g]++;
   endtask : take

   // each strobe of a pair is its own falling-edge clock
   for (genvar g = 0; g < `GROUPS; g++) begin : g_cap
      always @(negedge pins_i.data_strobe_p_side_n[g]
               or negedge pins_i.data_strobe_n_side_n[g]) begin
         if (!pins_oe_o.dstb && beats[g] < `BEATS) take(g);
      end
   end

   task automatic drive_line(input logic [`LINE_W-1:0] line);
      logic [15:0] t;
      pins_oe_o.data = 1'b1;
      pins_oe_o.dinv = 1'b1;
      pins_oe_o.dstb = 1'b1;
      for (int b = 0; b < `BEATS; b++) begin
         for (int g = 0; g < `GROUPS; g++) begin
            t = line[b*64 + g*16 +: 16];
            // too many lows in the plain image: send true data inverted
            if ($countones(t) > `MAX_LOW_BITS) begin
               pins_o.host_data_lines_n[g*16 +: 16] = t;
               pins_o.group_inversion_flags_n[g] = 1'b0;
            end else begin
               pins_o.host_data_lines_n[g*16 +: 16] = ~t;
               pins_o.group_inversion_flags_n[g] = 1'b1;
            end
         end
         pins_o.data_strobe_p_side_n = '1;
         pins_o.data_strobe_n_side_n = '1;
         #20;
         if (b % 2 == 0) pins_o.data_strobe_p_side_n = '0;
         else pins_o.data_strobe_n_side_n = '0;
         #20;
      end
      pins_o = '1;
      #20;
      pins_oe_o = '0;
   endtask : drive_line

   task automatic run_snoop(input logic [`ADDR_W-1:0] a,
                            input logic [`CMD_W-1:0] ca,
                            input logic [`CMD_W-1:0] cb);
      pins_oe_o.ads  = 1'b1;
      pins_oe_o.cmd  = 1'b1;
      pins_oe_o.addr = 1'b1;
      pins_oe_o.astb = 1'b1;
      pins_o.request_phase_strobe_n = 1'b0;
      pins_o.request_command_lines_n = ~ca;
      pins_o.host_address_lines_n = ~a;
      #40 pins_o.address_timing_strobes_n[0] = 1'b0;
      #40 pins_o.request_phase_strobe_n = 1'b1;
      pins_o.request_command_lines_n = ~cb;
      pins_o.address_timing_strobes_n[0] = 1'b1;
      #40 pins_o.address_timing_strobes_n[1] = 1'b0;
      #40 pins_o = '1;
      pins_oe_o = '0;
   endtask : run_snoop
endmodule : host_bus_device

// File: sim/test_host_bus_transfer_snoop.sv
// self-checking bench: host bus agent against the hub model
`include "host_bus_regs.svh"
module test_host_bus_transfer_snoop;
   timeunit 1ns;
   timeprecision 1ps;
   import host_bus_pkg::*;
   logic               mclk_i;
   logic               rstn_i;
   bus_pins_t          agent_pins;
   bus_pins_t          dev_pins;
   bus_pins_t          bus;
   bus_oe_t            agent_oe;
   bus_oe_t            dev_oe;
   logic               req_valid;
   logic               req_ready;
   req_t               req;
   logic [`LINE_W-1:0] wdata;
   logic               rd_valid;
   logic [`LINE_W-1:0] rd_data;
   logic               snp_valid;
   req_t               snp_req;
   logic               resp_valid;
   snp_resp_t          resp;
   logic [`LINE_W-1:0] snp_wdata;
   int                 errors;
   int                 tests_run;
   localparam logic [`LINE_W-1:0] LINE_A = {64'hFFFF_00FF_01FF_0000,
      64'h0000_FFFF_00FF_01FF, 64'h01FF_0000_FFFF_00FF,
      64'h00FF_01FF_0000_FFFF};

   // terminated wires: an undriven line floats high
   function automatic bus_pins_t spread(input bus_oe_t e);
      bus_pins_t m;
      m.request_phase_strobe_n   = e.ads;
      m.request_command_lines_n  = {`CMD_W{e.cmd}};
      m.host_address_lines_n     = {`ADDR_W{e.addr}};
      m.address_timing_strobes_n = {2{e.astb}};
      m.host_data_lines_n        = {`DATA_W{e.data}};
      m.group_inversion_flags_n  = {`GROUPS{e.dinv}};
      m.data_strobe_p_side_n     = {`GROUPS{e.dstb}};
      m.data_strobe_n_side_n     = {`GROUPS{e.dstb}};
      m.snoop_clean_hit_n        = e.hit;
      m.snoop_modified_hit_n     = e.hit;
      return m;
   endfunction : spread
   assign bus = (agent_pins | ~spread(agent_oe))
                & (dev_pins | ~spread(dev_oe));

   host_bus_agent i_host_bus_agent (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .pins_i(bus), .pins_o(agent_pins),
      .pins_oe_o(agent_oe), .req_valid_i(req_valid), .req_ready_o(req_ready),
      .req_i(req), .wdata_i(wdata), .rd_valid_o(rd_valid),
      .rd_data_o(rd_data), .snp_valid_o(snp_valid), .snp_req_o(snp_req),
      .snp_resp_valid_i(resp_valid), .snp_resp_i(resp),
      .snp_wdata_i(snp_wdata));
   host_bus_device i_host_bus_device (
      .pins_i(bus), .pins_o(dev_pins), .pins_oe_o(dev_oe));

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   task automatic wait_idle;
      int n;
      for (n = 0; n < 400 && agent_oe !== '0; n++) @(negedge mclk_i);
      check(n < 400, "agent never released the bus");
   endtask : wait_idle

   task automatic wait_beats;
      int n;
      for (n = 0; n < 400 && i_host_bus_device.beats[3] != 4; n++)
         @(negedge mclk_i);
      check(n < 400, "data phase incomplete");
   endtask : wait_beats

   task automatic do_req(input logic w, input logic [`LINE_W-1:0] d);
      int n;
      i_host_bus_device.clear();
      @(negedge mclk_i);
      req = '{write: w, addr: 33'h1_2345_6789, cmd_a: 5'h0A, cmd_b: 5'h15};
      wdata = d;
      req_valid = 1'b1;
      for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge mclk_i);
      @(negedge mclk_i);
      req_valid = 1'b0;
      check(n < 50, "request not taken");
   endtask : do_req

   task automatic check_adr;
      check(i_host_bus_device.cap_addr === 33'h1_2345_6789, "addr 1");
      check(i_host_bus_device.cap_addr_b === 33'h1_2345_6789, "addr 2");
      check(i_host_bus_device.cap_cmd_a === 5'h0A, "cmd half 1");
      check(i_host_bus_device.cap_cmd_b === 5'h15, "cmd half 2");
      check({i_host_bus_device.ads_a, i_host_bus_device.ads_b} === 2'b01,
            "phase strobe");
   endtask : check_adr

   task automatic t_write;
      do_req(1'b1, LINE_A);
      wait_beats();
      wait_idle();
      check_adr();
      check(i_host_bus_device.cap_line === LINE_A, "write line");
      check(i_host_bus_device.dbi_bad === 1'b0, "too many lows");
      $display("write test done");
   endtask : t_write

   task automatic t_read;
      int n;
      do_req(1'b0, '0);
      for (n = 0; n < 200 && i_host_bus_device.adr_seen == 0; n++)
         @(negedge mclk_i);
      wait_idle();
      check_adr();
      fork
         i_host_bus_device.drive_line(~LINE_A);
         for (n = 0; n < 200 && rd_valid !== 1'b1; n++) @(negedge mclk_i);
      join
      check(n < 200, "no read completion");
      check(rd_data === ~LINE_A, "read line");
      $display("read test done");
   endtask : t_read

   task automatic t_snoop(input snp_resp_t r);
      int n;
      i_host_bus_device.clear();
      snp_wdata = {4{64'hA5A5_FFF0_000F_7F80}};
      fork
         i_host_bus_device.run_snoop(33'h0_0ABC_DEF0, 5'h06, 5'h19);
         for (n = 0; n < 200 && snp_valid !== 1'b1; n++) @(negedge mclk_i);
      join
      check(n < 200, "snoop not seen");
      check(snp_req === req_t'{1'b0, 33'h0_0ABC_DEF0, 5'h06, 5'h19},
            "snoop req");
      repeat (3) @(negedge mclk_i);
      check({bus.snoop_clean_hit_n, bus.snoop_modified_hit_n} === 2'b00,
            "no stall shown");
      resp = '{clean: 1'b1, modified: 1'b1};
      resp_valid = 1'b1;
      @(negedge mclk_i);
      // the both-set answer is refused, so the stall must carry on
      resp_valid = 1'b0;
      resp = r;
      repeat (3) @(negedge mclk_i);
      check({bus.snoop_clean_hit_n, bus.snoop_modified_hit_n} === 2'b00,
            "stall not kept");
      resp_valid = 1'b1;
      @(negedge mclk_i);
      resp_valid = 1'b0;
      repeat (3) @(negedge mclk_i);
      check(bus.snoop_clean_hit_n === ~r.clean, "clean result");
      check(bus.snoop_modified_hit_n === ~r.modified, "mod result");
      if (r.modified && !r.clean) begin
         wait_beats();
         check(i_host_bus_device.cap_line === snp_wdata, "line supplied");
      end
      wait_idle();
      $display("snoop test done");
   endtask : t_snoop

   initial begin
      errors = 0;
      tests_run = 0;
      rstn_i = 1'b0;
      req_valid = 1'b0;
      req = '0;
      wdata = '0;
      resp_valid = 1'b0;
      resp = '0;
      snp_wdata = '0;
      repeat (3) @(negedge mclk_i);
      check(agent_oe === '0 && agent_pins === '1, "reset levels");
      rstn_i = 1'b1;
      t_write();
      t_read();
      t_snoop('{clean: 1'b1, modified: 1'b0});
      t_snoop('{clean: 1'b0, modified: 1'b1});
      t_snoop('{clean: 1'b0, modified: 1'b0});
      // back-to-back after a snoop that hit neither clean nor modified
      t_write();
      wrap_up();
   end

   // every scenario finishes in a few microseconds
   initial begin
      #200000;
      errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      wrap_up();
   end
endmodule : test_host_bus_transfer_snoop
